// [src/iso_defines.svh]
`ifndef ISO_DEFINES_SVH
`define ISO_DEFINES_SVH
`define ISO_OP_INC_SKIP_MASK 12'hfc0
`define ISO_OP_INC_SKIP_VAL 12'h3c0
`define ISO_OP_OR_LIT_MASK 12'hf00
`define ISO_OP_OR_LIT_VAL 12'hd00
`define ISO_OP_OR_REG_MASK 12'hfc0
`define ISO_OP_OR_REG_VAL 12'h100
`define ISO_IDLE_WORD 12'h000
`define ISO_DEST_BIT 5
`define ISO_SEL_MSB 4
`define ISO_LIT_MSB 7
`define ISO_FILE_DEPTH 32
`define ISO_ACCUM_RESET 8'h00
`define ISO_ZERO_RESET 1'b0
`endif

// [src/iso_pkg.sv]
package iso_pkg;
    typedef logic [11:0] iso_word_type;
    typedef logic [7:0] iso_data_type;
    typedef logic [4:0] iso_sel_type;
    typedef enum logic [1:0] {
        ISO_KIND_NONE,
        ISO_KIND_INC_SKIP,
        ISO_KIND_OR_LIT,
        ISO_KIND_OR_REG
    } iso_kind_type;
endpackage

// [src/iso_file_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface iso_file_if;
    import iso_pkg::*;
    iso_sel_type rd_sel;
    iso_data_type rd_data;
    logic wr_en;
    iso_sel_type wr_sel;
    iso_data_type wr_data;
    modport core (output rd_sel, input rd_data, output wr_en, output wr_sel, output wr_data);
    modport mem (input rd_sel, output rd_data, input wr_en, input wr_sel, input wr_data);
endinterface
`default_nettype wire

// [src/iso_file_mem.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iso_defines.svh"
module iso_file_mem (
    input wire logic ref_clk,
    iso_file_if.mem fport
);
    import iso_pkg::*;
    iso_data_type mem_reg [`ISO_FILE_DEPTH];
    iso_data_type rd_reg;
    // read data registered: core sees the file one cycle after presenting rd_sel
    always_ff @(posedge ref_clk) begin
        if (fport.wr_en) begin
            mem_reg[fport.wr_sel] <= fport.wr_data;
        end
        rd_reg <= mem_reg[fport.rd_sel];
    end
    assign fport.rd_data = rd_reg;
endmodule
`default_nettype wire

// [src/iso_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iso_defines.svh"
module iso_core (
    input wire logic ref_clk,
    input wire logic rst,
    input wire iso_pkg::iso_word_type instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    output iso_pkg::iso_data_type accum_out,
    output logic zero_flag,
    output logic skip_pulse,
    output logic done_pulse
);
    import iso_pkg::*;

    // =========================================
    // decode
    function automatic iso_kind_type decode_word(input iso_word_type w);
        if ((w & `ISO_OP_INC_SKIP_MASK) == `ISO_OP_INC_SKIP_VAL) begin
            return ISO_KIND_INC_SKIP;
        end else if ((w & `ISO_OP_OR_LIT_MASK) == `ISO_OP_OR_LIT_VAL) begin
            return ISO_KIND_OR_LIT;
        end else if ((w & `ISO_OP_OR_REG_MASK) == `ISO_OP_OR_REG_VAL) begin
            return ISO_KIND_OR_REG;
        end
        return ISO_KIND_NONE;
    endfunction

    function automatic iso_data_type bump_byte(input iso_data_type v);
        return v + 8'h01;
    endfunction

    function automatic iso_data_type merge_bytes(input iso_data_type a, input iso_data_type b);
        return a | b;
    endfunction

    function automatic logic is_null(input iso_data_type v);
        return (v == 8'h00);
    endfunction

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SKIP} iso_state_type;

    iso_file_if fbus ();
    iso_file_mem u_mem (
        .ref_clk(ref_clk),
        .fport(fbus.mem)
    );

    iso_state_type state_reg, state_next;
    iso_word_type word_reg, word_next;
    iso_data_type accum_reg, accum_next;
    logic zero_reg, zero_next;
    logic skip_reg, skip_next;
    logic done_reg, done_next;
    iso_kind_type kind;
    iso_sel_type file_sel;
    iso_data_type lit_val;
    iso_data_type inc_val;
    iso_data_type or_lit_val;
    iso_data_type or_val;
    logic dest;
    logic in_exec;
    logic skip_due;

    // =========================================
    // datapath
    always_comb begin
        kind = decode_word(word_reg);
        dest = word_reg[`ISO_DEST_BIT];
        file_sel = word_reg[`ISO_SEL_MSB:0];
        lit_val = word_reg[`ISO_LIT_MSB:0];
        in_exec = (state_reg == ST_EXEC);
        inc_val = bump_byte(fbus.rd_data);
        or_lit_val = merge_bytes(accum_reg, lit_val);
        or_val = merge_bytes(accum_reg, fbus.rd_data);
        // only a wrapped increment skips; the OR results never do
        skip_due = (kind == ISO_KIND_INC_SKIP) && is_null(inc_val);
    end

    // fetch accepted only in idle; read address is taken straight off the word
    assign instr_ready = (state_reg == ST_IDLE);
    assign fbus.rd_sel = instr_word[`ISO_SEL_MSB:0];

    // =========================================
    // control
    always_comb begin
        state_next = state_reg;
        word_next = word_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (instr_valid) begin
                    word_next = instr_word;
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (skip_due) begin
                    // no next word is taken while instr_ready is low, idle slot inserted
                    state_next = ST_SKIP;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_SKIP: begin
                // acts as the idle instruction, second cycle
                state_next = ST_IDLE;
            end
            default: begin
                // unused code of the two-bit state: recover to idle
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            word_reg <= `ISO_IDLE_WORD;
        end else begin
            state_reg <= state_next;
            word_reg <= word_next;
        end
    end

    // =========================================
    // accumulator and zero flag
    always_comb begin
        accum_next = accum_reg;
        zero_next = zero_reg;
        if (in_exec) begin
            unique case (kind)
                ISO_KIND_INC_SKIP: begin
                    // flags untouched on purpose
                    if (!dest) begin
                        accum_next = inc_val;
                    end
                end
                ISO_KIND_OR_LIT: begin
                    accum_next = or_lit_val;
                    zero_next = is_null(or_lit_val);
                end
                ISO_KIND_OR_REG: begin
                    if (!dest) begin
                        accum_next = or_val;
                    end
                    zero_next = is_null(or_val);
                end
                ISO_KIND_NONE: begin
                    // other opcodes belong to the rest of the core
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            accum_reg <= `ISO_ACCUM_RESET;
            zero_reg <= `ISO_ZERO_RESET;
        end else begin
            accum_reg <= accum_next;
            zero_reg <= zero_next;
        end
    end

    // =========================================
    // file write-back
    always_comb begin
        fbus.wr_en = 1'b0;
        fbus.wr_sel = file_sel;
        fbus.wr_data = 8'h00;
        if (in_exec && dest) begin
            unique case (kind)
                ISO_KIND_INC_SKIP: begin
                    fbus.wr_en = 1'b1;
                    fbus.wr_data = inc_val;
                end
                ISO_KIND_OR_REG: begin
                    fbus.wr_en = 1'b1;
                    fbus.wr_data = or_val;
                end
                ISO_KIND_OR_LIT, ISO_KIND_NONE: begin
                    // bit 5 of a literal word is data, not a destination
                    fbus.wr_en = 1'b0;
                end
            endcase
        end
    end

    // =========================================
    // retire pulses
    always_comb begin
        skip_next = 1'b0;
        done_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                done_next = 1'b0;
            end
            ST_EXEC: begin
                // a skipping increment retires only after its idle slot
                done_next = !skip_due;
            end
            ST_SKIP: begin
                skip_next = 1'b1;
                done_next = 1'b1;
            end
            default: begin
                done_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            skip_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            skip_reg <= skip_next;
            done_reg <= done_next;
        end
    end

    assign accum_out = accum_reg;
    assign zero_flag = zero_reg;
    assign skip_pulse = skip_reg;
    assign done_pulse = done_reg;
endmodule
`default_nettype wire

// [sim/iso_core_props.sv]
`timescale 1ns/1ps
`default_nettype none
module iso_core_props import iso_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire iso_word_type instr_word,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire iso_data_type accum_out,
    input wire logic zero_flag,
    input wire logic skip_pulse,
    input wire logic done_pulse
);
    // ==========
    // decode
    wire take = instr_valid & instr_ready;
    wire is_inc = instr_word[11:6] == 6'h0f;
    wire is_orr = instr_word[11:6] == 6'h04;
    wire is_lit = instr_word[11:8] == 4'hd;
    wire to_file = instr_word[5];
    wire [7:0] lit = instr_word[7:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========
    // properties
    sequence s_skip;
        !done_pulse ##1 (skip_pulse && done_pulse);
    endsequence
    // results are visible two edges after the take, the skip slot one edge later
    sequence s_inc_w;
        take && is_inc && !to_file ##2 1'b1;
    endsequence
    property p_inc_flag;
        take && is_inc |=> $stable(zero_flag) [*2];
    endproperty
    a_inc_flag: assert property (p_inc_flag) else $error("flag moved");
    property p_inc_file;
        take && is_inc && to_file |-> ##2 accum_out == $past(accum_out, 2);
    endproperty
    a_inc_file: assert property (p_inc_file) else $error("accum hit");
    property p_skip;
        s_inc_w |-> if (accum_out == 8'h00) s_skip else (done_pulse && !skip_pulse);
    endproperty
    a_skip: assert property (p_skip) else $error("skip timing");
    property p_or_lit;
        take && is_lit |-> ##2 done_pulse && accum_out == ($past(accum_out, 2) | $past(lit, 2));
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("or literal");
    property p_or_reg_w;
        take && is_orr && !to_file |-> ##2 done_pulse
            && (accum_out & $past(accum_out, 2)) == $past(accum_out, 2);
    endproperty
    a_or_reg_w: assert property (p_or_reg_w) else $error("or register");
    property p_or_reg_f;
        take && is_orr && to_file |-> ##2 done_pulse && accum_out == $past(accum_out, 2);
    endproperty
    a_or_reg_f: assert property (p_or_reg_f) else $error("or dest");
    property p_or_zero;
        take && (is_lit || (is_orr && !to_file)) |-> ##2 zero_flag == (accum_out == 8'h00);
    endproperty
    a_or_zero: assert property (p_or_zero) else $error("zero flag");
endmodule
bind iso_core iso_core_props u_props (.ref_clk, .rst, .instr_word, .instr_valid,
    .instr_ready, .accum_out, .zero_flag, .skip_pulse, .done_pulse);
`default_nettype wire

// [sim/increment_skip_and_or_ops_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module increment_skip_and_or_ops_tb;
    import iso_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    iso_word_type instr_word = 12'h000;
    logic instr_valid = 1'b0;
    logic instr_ready, zero_flag, skip_pulse, done_pulse;
    iso_data_type accum_out;
    int errors = 0;
    int compares = 0;
    int seed = 75;
    int cycles = 0;
    int acc = 0;
    int zf = 0;
    int file [32];
    iso_core DUT (.ref_clk(ref_clk), .rst(rst), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .accum_out(accum_out),
        .zero_flag(zero_flag), .skip_pulse(skip_pulse), .done_pulse(done_pulse));
    initial forever #5 ref_clk = ~ref_clk;
    // ==========
    // hang guard, run needs about 770 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            errors++;
            conclude();
        end
    end
    task conclude;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ==========
    // one instruction, model first; called at a falling edge
    task run(input iso_word_type w);
        int n, r, sk, s, d;
        s = w[4:0];
        d = w[5];
        sk = 0;
        if (w[11:6] == 6'h0f) begin
            r = (file[s] + 1) % 256;
            sk = r == 0;
            if (d) file[s] = r; else acc = r;
        end else if (w[11:8] == 4'hd) begin
            acc = acc | w[7:0];
            zf = acc == 0;
        end else if (w[11:6] == 6'h04) begin
            r = acc | file[s];
            zf = r == 0;
            if (d) file[s] = r; else acc = r;
        end
        chk({7'h00, instr_ready}, 8'h01);
        instr_word = w;
        instr_valid = 1'b1;
        @(posedge ref_clk);
        n = 0;
        do begin
            @(negedge ref_clk);
            if (n == 0) instr_valid = 1'b0;
            n++;
        end while (done_pulse !== 1'b1 && n < 8);
        chk(n[7:0], sk ? 8'h03 : 8'h02);
        chk({7'h00, skip_pulse}, sk[7:0]);
        chk(accum_out, acc[7:0]);
        chk({7'h00, zero_flag}, zf[7:0]);
    endtask
    initial begin
        iso_word_type w;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        run(12'hd00);
        run(12'hdff);
        // file powers up unknown, so fill it before any random use
        for (int i = 0; i < 32; i++) run({6'h04, 1'b1, i[4:0]});
        for (int i = 0; i < 32; i++) run({6'h0f, i[0], i[4:0]});
        for (int i = 0; i < 300; i++) begin
            w = iso_word_type'($random(seed));
            case (w[9:8])
                2'd0: w[11:6] = 6'h0f;
                2'd1: w[11:8] = 4'hd;
                2'd2: w[11:6] = 6'h04;
                default: w[11:8] = 4'he;
            endcase
            run(w);
        end
        conclude();
    end
endmodule
`default_nettype wire
